// ==== ec_ctrl_bits.sv ====
// Control register bank and audio path steering for the echo canceller
//
// Our own choices: the address map and the address-and-strobe port.
`timescale 1ns/100ps
module ec_ctrl_bits (
	input  wire logic                            mclk_i,
	input  wire logic                            reset_i,
	input  wire logic [3:0]                      addr_i,
	input  wire logic [7:0]                      wdata_i,
	input  wire logic                            wr_i,
	input  wire logic                            rd_i,
	output logic [7:0]                           rdata_o,
	input  wire ec_ctrl_pkg::sample_pair_t       raw_i,
	input  wire ec_ctrl_pkg::sample_pair_t       nlp_i,
	output ec_ctrl_pkg::sample_pair_t            audio_o,
	output ec_ctrl_pkg::engine_ctrl_t            engine_o,
	output ec_ctrl_pkg::acoustic_control_t       acoustic_o
);
	import ec_ctrl_pkg::*;

	main_control_t     main_reg;
	acoustic_control_t acoustic_reg;
	logic [7:0]        rdata_reg;
	logic              init_reg;
	sample_pair_t      audio_next;
	sample_pair_t      audio_reg;
	main_control_t     wr_fields;

	// ==========================================
	// Register writes
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			main_reg <= MAIN_CONTROL_RESET;
		end else if (wr_i && addr_i == ADDR_MAIN_CONTROL) begin
			main_reg <= wdata_i;
		end
	end

	// Acoustic control register
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			acoustic_reg <= ACOUSTIC_RESET;
		end else if (wr_i && addr_i == ADDR_ACOUSTIC_CONTROL) begin
			acoustic_reg <= wdata_i;
		end
	end

	// Write data viewed through the main control layout
	assign wr_fields = wdata_i;

	// One-cycle start pulse when init bit written one
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			init_reg <= 1'b0;
		end else begin
			init_reg <= wr_i && addr_i == ADDR_MAIN_CONTROL && wr_fields.power_init;
		end
	end

	// ==========================================
	// Register reads, data in the following cycle
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			rdata_reg <= READ_UNMAPPED;
		end else if (rd_i) begin
			if (addr_i == ADDR_MAIN_CONTROL) begin
				rdata_reg <= main_reg;
			end else if (addr_i == ADDR_ACOUSTIC_CONTROL) begin
				rdata_reg <= acoustic_reg;
			end else begin
				rdata_reg <= READ_UNMAPPED;
			end
		end else begin
			rdata_reg <= READ_UNMAPPED;
		end
	end

	assign rdata_o = rdata_reg;

	// ==========================================
	// Audio path selection: bypass, mute, shift
	always_comb begin
		audio_next = nlp_i;
		if (main_reg.shift_enable) begin
			audio_next.receive = nlp_i.receive << SHIFT_BITS;
			audio_next.send    = nlp_i.send << SHIFT_BITS;
		end
		if (main_reg.receive_mute) begin
			audio_next.receive = QUIET_CODE;
		end
		if (main_reg.send_mute) begin
			audio_next.send = QUIET_CODE;
		end
		if (main_reg.path_bypass) begin
			audio_next = raw_i;
		end
	end

	// Registered audio outputs
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			audio_reg <= '0;
		end else begin
			audio_reg <= audio_next;
		end
	end

	assign audio_o = audio_reg;

	// ==========================================
	// Engine enables
	assign engine_o.gain_control_on       = ~main_reg.gain_control_disable;
	assign engine_o.howling_detect_on     = ~main_reg.howling_detect_disable;
	assign engine_o.narrowband_receive_on = ~main_reg.narrowband_detect_disable;
	assign engine_o.narrowband_send_on    = ~main_reg.narrowband_detect_disable;
	assign engine_o.power_init_start      = init_reg;
	assign acoustic_o                     = acoustic_reg;

	// ==========================================
	// Checks: engine enables
	// Gain control enable is the inverse of its disable bit
	a_gain_ctrl_follows: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		engine_o.gain_control_on != main_reg.gain_control_disable)
		else $error("gain control enable wrong");

	// A main control write sets the gain control enable
	a_gain_from_write: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && wr_i && addr_i == ADDR_MAIN_CONTROL
		|=> engine_o.gain_control_on == !$past(wr_fields.gain_control_disable))
		else $error("gain control enable not taken from write");

	// Howling detector enable is the inverse of its disable bit
	a_howling_follows: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		engine_o.howling_detect_on == !main_reg.howling_detect_disable)
		else $error("howling enable wrong");

	// A main control write sets the howling detector enable
	a_howling_from_write: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && wr_i && addr_i == ADDR_MAIN_CONTROL
		|=> engine_o.howling_detect_on == !$past(wr_fields.howling_detect_disable))
		else $error("howling enable not taken from write");

	// Both narrowband detectors share one disable bit
	a_narrowband_both: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		engine_o.narrowband_receive_on == engine_o.narrowband_send_on
		&& engine_o.narrowband_send_on == !main_reg.narrowband_detect_disable)
		else $error("narrowband enables wrong");

	// A main control write sets both narrowband enables
	a_narrowband_from_write: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && wr_i && addr_i == ADDR_MAIN_CONTROL
		|=> engine_o.narrowband_receive_on == !$past(wr_fields.narrowband_detect_disable)
		&& engine_o.narrowband_send_on == !$past(wr_fields.narrowband_detect_disable))
		else $error("narrowband enables not taken from write");

	// Writing the init bit one starts the routine next cycle
	a_init_pulse: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && wr_i && addr_i == ADDR_MAIN_CONTROL && wr_fields.power_init
		|=> engine_o.power_init_start)
		else $error("init pulse missing");

	// No start pulse without a main control write
	a_init_needs_write: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && !(wr_i && addr_i == ADDR_MAIN_CONTROL)
		|=> !engine_o.power_init_start)
		else $error("init pulse without write");

	// Writing the init bit zero starts nothing
	a_init_zero_write: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && wr_i && addr_i == ADDR_MAIN_CONTROL && !wr_fields.power_init
		|=> !engine_o.power_init_start)
		else $error("init pulse on zero write");

	// ==========================================
	// Checks: audio paths
	// Receive mute gives quiet code unless bypassed
	a_receive_mute_quiet: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && main_reg.receive_mute && !main_reg.path_bypass
		|=> audio_o.receive == QUIET_CODE)
		else $error("receive not muted");

	// Send mute gives quiet code unless bypassed
	a_send_mute_quiet: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && main_reg.send_mute && !main_reg.path_bypass
		|=> audio_o.send == QUIET_CODE)
		else $error("send not muted");

	// Bypass carries raw samples on both paths
	a_bypass_raw: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && main_reg.path_bypass
		|=> audio_o == $past(raw_i))
		else $error("bypass not transparent");

	// Receive path unshifted while shift is off
	a_shift_plain: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && !main_reg.shift_enable && !main_reg.path_bypass && !main_reg.receive_mute
		|=> audio_o.receive == $past(nlp_i.receive))
		else $error("unshifted path altered");

	// Send path unshifted while shift is off
	a_send_plain: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && !main_reg.shift_enable && !main_reg.path_bypass && !main_reg.send_mute
		|=> audio_o.send == $past(nlp_i.send))
		else $error("unshifted send path altered");

	// Receive path shifted while shift is on
	a_receive_shifted: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && main_reg.shift_enable && !main_reg.path_bypass && !main_reg.receive_mute
		|=> audio_o.receive == 8'($past(nlp_i.receive) << SHIFT_BITS))
		else $error("receive path not shifted");

	// Send path shifted while shift is on
	a_send_shifted: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && main_reg.shift_enable && !main_reg.path_bypass && !main_reg.send_mute
		|=> audio_o.send == 8'($past(nlp_i.send) << SHIFT_BITS))
		else $error("send path not shifted");

	// Audio outputs cleared while in reset
	a_audio_reset: assert property (
		@(posedge mclk_i)
		reset_i
		|=> audio_o == '0)
		else $error("audio not cleared by reset");

	// ==========================================
	// Checks: register port and reset
	// Write then read with no gap returns the written value
	a_read_back: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && wr_i && addr_i == ADDR_MAIN_CONTROL ##1 rd_i && addr_i == ADDR_MAIN_CONTROL
		|=> rdata_o == $past(wdata_i, 2))
		else $error("read back mismatch");

	// Main control takes the written byte
	a_main_takes_write: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && wr_i && addr_i == ADDR_MAIN_CONTROL
		|=> main_reg == $past(wdata_i))
		else $error("main control write lost");

	// Main control holds without its write
	a_main_holds: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && !(wr_i && addr_i == ADDR_MAIN_CONTROL)
		|=> $stable(main_reg))
		else $error("main control changed without write");

	// Acoustic control takes the written byte
	a_acoustic_takes_write: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && wr_i && addr_i == ADDR_ACOUSTIC_CONTROL
		|=> acoustic_o == $past(wdata_i))
		else $error("acoustic control write lost");

	// Acoustic control holds without its write
	a_acoustic_holds: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && !(wr_i && addr_i == ADDR_ACOUSTIC_CONTROL)
		|=> $stable(acoustic_o))
		else $error("acoustic control changed without write");

	// Main control read returns the stored byte
	a_read_main_value: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && rd_i && addr_i == ADDR_MAIN_CONTROL
		|=> rdata_o == $past(main_reg))
		else $error("main control read wrong");

	// Acoustic control read returns the stored byte
	a_read_acoustic: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && rd_i && addr_i == ADDR_ACOUSTIC_CONTROL
		|=> rdata_o == $past(acoustic_o))
		else $error("acoustic control read wrong");

	// Unmapped reads return the fill value
	a_read_unmapped: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && rd_i && addr_i != ADDR_MAIN_CONTROL && addr_i != ADDR_ACOUSTIC_CONTROL
		|=> rdata_o == READ_UNMAPPED)
		else $error("unmapped read not filled");

	// Read data stand only after a read strobe
	a_rdata_idle: assert property (
		@(posedge mclk_i) disable iff (reset_i)
		!reset_i && !rd_i
		|=> rdata_o == READ_UNMAPPED)
		else $error("read data without strobe");

	// Registers and read data return to reset values
	a_regs_reset: assert property (
		@(posedge mclk_i)
		reset_i
		|=> main_reg == MAIN_CONTROL_RESET && acoustic_o == ACOUSTIC_RESET
		&& rdata_o == READ_UNMAPPED)
		else $error("registers not reset");

	// No start pulse while in reset
	a_init_reset: assert property (
		@(posedge mclk_i)
		reset_i
		|=> !engine_o.power_init_start)
		else $error("init pulse during reset");

endmodule : ec_ctrl_bits

// ==== ec_ctrl_pkg.sv ====
// Constants and types for the echo canceller control register bank
//
// Overview of operation
// - Gain control disable bit high switches off speaker path automatic gain control.
// - Howling detect disable bit high stops the howling detector.
// - Receive mute high replaces receive samples with quiet code after nonlinear stage, unless path bypass is high.
// - Send mute high forces send samples to quiet code after nonlinear stage, unless path bypass is high.
// - Path bypass high passes send and receive samples unchanged.
// - Narrowband detect disable high turns off both narrowband detectors.
// - Writing power initialisation bit one starts the preset-state restore routine.
// - Two-bit sample shift applies only while its control bit is one.
package ec_ctrl_pkg;
	// ==========================================
	// Register map
	localparam logic [3:0] ADDR_MAIN_CONTROL     = 4'h0;
	localparam logic [3:0] ADDR_ACOUSTIC_CONTROL = 4'h1;
	localparam logic [7:0] MAIN_CONTROL_RESET    = 8'h00;
	localparam logic [7:0] ACOUSTIC_RESET        = 8'h00;
	localparam logic [7:0] READ_UNMAPPED         = 8'h00;
	localparam logic [7:0] QUIET_CODE            = 8'h00;
	localparam int         SHIFT_BITS            = 2;

	// ==========================================
	// Main control field layout
	typedef struct packed {
		logic shift_enable;
		logic power_init;
		logic howling_detect_disable;
		logic gain_control_disable;
		logic narrowband_detect_disable;
		logic path_bypass;
		logic send_mute;
		logic receive_mute;
	} main_control_t;

	// Acoustic canceller control field layout
	typedef struct packed {
		logic weighting_disable;
		logic adaptation_disable_speed_control_disable;
		logic nonlinear_processor_disable;
		logic noise_injection_disable;
		logic highpass_filter_bypass;
		logic filter_coefficient_clear;
		logic adaptation_disable;
		logic canceller_bypass;
	} acoustic_control_t;

	// Audio sample pair carried by each path
	typedef struct packed {
		logic [7:0] receive;
		logic [7:0] send;
	} sample_pair_t;

	// Detector and processing enables derived from the bits
	typedef struct packed {
		logic gain_control_on;
		logic howling_detect_on;
		logic narrowband_receive_on;
		logic narrowband_send_on;
		logic power_init_start;
	} engine_ctrl_t;
endpackage : ec_ctrl_pkg

// ==== ec_host_model.sv ====
// Host software model on the register port
`timescale 1ns/100ps
module ec_host_model (
	input  wire logic       mclk_i,
	output logic [3:0]      addr_o,
	output logic [7:0]      wdata_o,
	output logic            wr_o,
	output logic            rd_o,
	input  wire logic [7:0] rdata_i
);
	// Idle bus from time zero
	initial begin
		addr_o = 4'h0;
		wdata_o = 8'h00;
		wr_o = 1'b0;
		rd_o = 1'b0;
	end
	// One-cycle write strobe
	task automatic write_reg(input logic [3:0] a, input logic [7:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge mclk_i);
		wr_o <= 1'b0;
	endtask : write_reg
	// Read strobe, data taken in the following cycle only
	task automatic read_reg(input logic [3:0] a, output logic [7:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask : read_reg
	// Write then read back, strobes with no gap between them
	task automatic write_read(input logic [3:0] a, input logic [7:0] w, output logic [7:0] d);
		@(posedge mclk_i);
		addr_o <= a;
		wdata_o <= w;
		wr_o <= 1'b1;
		@(posedge mclk_i);
		wr_o <= 1'b0;
		rd_o <= 1'b1;
		@(posedge mclk_i);
		rd_o <= 1'b0;
		#1;
		d = rdata_i;
	endtask : write_read
endmodule : ec_host_model

// ==== echo_canceller_control_bits_tb_top.sv ====
// Self-checking bench for the control register bank
`timescale 1ns/100ps
module echo_canceller_control_bits_tb_top;
	import ec_ctrl_pkg::*;
	logic [3:0] addr;
	logic [7:0] wdata, rdata, got, m;
	logic mclk_i, reset_i, wr, rd;
	sample_pair_t raw, nlp, audio;
	engine_ctrl_t engine;
	acoustic_control_t acoustic;
	int err_count, checks, cycles, seed;
	ec_host_model host (.mclk_i(mclk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr),
		.rd_o(rd), .rdata_i(rdata));
	ec_ctrl_bits dut (.mclk_i(mclk_i), .reset_i(reset_i), .addr_i(addr), .wdata_i(wdata),
		.wr_i(wr), .rd_i(rd), .rdata_o(rdata), .raw_i(raw), .nlp_i(nlp), .audio_o(audio),
		.engine_o(engine), .acoustic_o(acoustic));
	// 10 MHz clock and cycle ceiling
	initial begin
		mclk_i = 1'b0;
		forever #50 mclk_i = ~mclk_i;
	end
	always @(posedge mclk_i) begin
		cycles++;
		if (cycles == 4000) begin
			err_count++;
			finish_test();
		end
	end
	// Verdict and end of run
	task automatic finish_test();
		if (err_count == 0 && checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : finish_test
	// Compare one value
	task automatic cmp(input string n, input logic [15:0] e, input logic [15:0] g);
		checks++;
		if (g !== e) begin
			err_count++;
			$display("unexpected %s exp %h got %h", n, e, g);
		end
	endtask : cmp
	// Expected enables from a main control value
	function automatic logic [15:0] eng(logic [7:0] v);
		main_control_t c;
		c = v;
		return 16'({~c.gain_control_disable, ~c.howling_detect_disable,
			~c.narrowband_detect_disable, ~c.narrowband_detect_disable, c.power_init});
	endfunction : eng
	// Expected sample of one path
	function automatic logic [7:0] pth(logic [7:0] v, logic mu, logic [7:0] r, logic [7:0] n);
		main_control_t c;
		c = v;
		return c.path_bypass ? r : mu ? QUIET_CODE : c.shift_enable ? 8'(n << SHIFT_BITS) : n;
	endfunction : pth
	// Reset, then random and corner main control values
	initial begin
		seed = 81993;
		raw = '0;
		nlp = '0;
		reset_i = 1'b1;
		repeat (20) @(posedge mclk_i);
		reset_i <= 1'b0;
		#1;
		cmp("engine", eng(MAIN_CONTROL_RESET), 16'(engine));
		for (int i = 0; i < 40; i++) begin
			m = (i == 0) ? 8'hff : (i == 1) ? 8'h84 : (i == 2) ? 8'h43 : 8'($random(seed));
			@(posedge mclk_i);
			raw <= 16'($random(seed));
			nlp <= 16'($random(seed));
			host.write_reg(ADDR_MAIN_CONTROL, m);
			#1;
			cmp("engine", eng(m), 16'(engine));
			@(posedge mclk_i);
			#1;
			cmp("engine", eng(m & 8'hbf), 16'(engine));
			cmp("audio", {pth(m, m[0], raw.receive, nlp.receive),
				pth(m, m[1], raw.send, nlp.send)}, 16'(audio));
			host.write_read(ADDR_MAIN_CONTROL, m, got);
			cmp("main", 16'(m), 16'(got));
			@(posedge mclk_i);
			#1;
			cmp("rdata_idle", 16'(READ_UNMAPPED), 16'(rdata));
		end
		host.write_reg(ADDR_ACOUSTIC_CONTROL, 8'h5a);
		host.write_reg(4'hf, 8'hff);
		host.read_reg(4'hf, got);
		cmp("unmapped", 16'(READ_UNMAPPED), 16'(got));
		host.read_reg(ADDR_MAIN_CONTROL, got);
		cmp("main", 16'(m), 16'(got));
		host.read_reg(ADDR_ACOUSTIC_CONTROL, got);
		cmp("acoustic", 16'h005a, 16'(got));
		cmp("acoustic_o", 16'h005a, 16'(acoustic));
		@(posedge mclk_i);
		reset_i <= 1'b1;
		repeat (3) @(posedge mclk_i);
		reset_i <= 1'b0;
		#1;
		cmp("audio", 16'h0000, 16'(audio));
		cmp("acoustic_o", 16'(ACOUSTIC_RESET), 16'(acoustic));
		cmp("engine", eng(MAIN_CONTROL_RESET), 16'(engine));
		host.read_reg(ADDR_MAIN_CONTROL, got);
		cmp("main", 16'(MAIN_CONTROL_RESET), 16'(got));
		finish_test();
	end
endmodule : echo_canceller_control_bits_tb_top
